// file: rtl/ccl_pkg.sv
package ccl_pkg;

    // Widths of the analog voltage codes (millivolts) and of the bus.
    localparam int MV_W   = 12;
    localparam int ADDR_W = 5;

    // Register byte addresses on the bus.
    localparam logic [ADDR_W-1:0] A_CTRL_B  = 5'h00;
    localparam logic [ADDR_W-1:0] A_CSR     = 5'h04;
    localparam logic [ADDR_W-1:0] A_DIDR    = 5'h08;
    localparam logic [ADDR_W-1:0] A_CONV    = 5'h0C;
    localparam logic [ADDR_W-1:0] A_ISTAT   = 5'h10;
    localparam logic [ADDR_W-1:0] A_IMASK   = 5'h14;

    // Field positions of comparator_control_status.
    localparam int CSR_POWER_OFF = 7;
    localparam int CSR_INT_REF   = 6;
    localparam int CSR_RESULT    = 5;
    localparam int CSR_FLAG      = 4;
    localparam int CSR_IRQ_EN    = 3;
    localparam int CSR_CAPTURE   = 2;
    localparam int CSR_EVSEL_HI  = 1;

    // Field positions of converter_control_b.
    localparam int CTB_MUX_EN   = 6;
    localparam int CTB_DIV_HI   = 5;
    localparam int CTB_TRIG_HI  = 2;

    // Field positions of digital_input_disable_0.
    localparam int DID_POS_OFF = 7;
    localparam int DID_NEG_OFF = 6;

    // Field positions of the converter settings register.
    localparam int CNV_ENABLE = 7;
    localparam int CNV_REF_HI = 6;
    localparam int CNV_CH_HI  = 4;

    // Interrupt status and mask bit.
    localparam int IRQ_EVENT = 0;

    // Reset values.
    localparam logic [7:0] RST_BYTE = 8'h00;

    // Event select codes.
    localparam logic [1:0] EV_TOGGLE  = 2'h0;
    localparam logic [1:0] EV_FALLING = 2'h2;
    localparam logic [1:0] EV_RISING  = 2'h3;

    // Converter reference field codes that select an internal reference.
    localparam logic [1:0] REF_SEL_1V1  = 2'h1;
    localparam logic [1:0] REF_SEL_2V56 = 2'h3;

    // Reference voltages in millivolts.
    localparam logic [MV_W-1:0] MV_1V1  = 12'h44C;
    localparam logic [MV_W-1:0] MV_2V56 = 12'hA00;

    // Highest legal multiplexer channel code.
    localparam logic [4:0] CH_MAX = 5'h0A;
    localparam int         N_CH   = 11;

    // Analog voltages seen at the comparator pins.
    typedef struct packed {
        logic [MV_W-1:0] pos_pin_mv;
        logic [MV_W-1:0] neg_pin_mv;
    } ccl_pins_t;

    // Avalon-MM request from the master.
    typedef struct packed {
        logic              read;
        logic              write;
        logic [ADDR_W-1:0] address;
        logic [31:0]       writedata;
        logic [3:0]        byteenable;
    } ccl_avs_req_t;

    // Avalon-MM answer to the master.
    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } ccl_avs_rsp_t;

endpackage

// file: rtl/ccl_comparator_ctrl.sv
module ccl_comparator_ctrl
    import ccl_pkg::*;
#(
    parameter int SYNC_STAGES = 2
)
(
    input  wire logic                               clk,
    input  wire logic                               nrst,
    input  wire ccl_pkg::ccl_avs_req_t              avs_req,
    output ccl_pkg::ccl_avs_rsp_t                   avs_rsp,
    input  wire ccl_pkg::ccl_pins_t                 pins,
    input  wire logic [ccl_pkg::N_CH-1:0][ccl_pkg::MV_W-1:0] channel_mv,
    input  wire logic [1:0]                         pin_digital_in,
    input  wire logic                               global_irq_enable,
    input  wire logic                               irq_taken,
    output logic                                    irq,
    output logic                                    capture_trigger,
    output logic                                    comparator_power_off,
    output logic [1:0]                              pin_input_off,
    output logic [1:0]                              port_input
);
    import ccl_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Register state.
    logic [7:0]              ctrl_b_q;
    logic                    power_off_q;
    logic                    int_ref_q;
    logic                    flag_q;
    logic                    flag_d;
    logic                    irq_en_q;
    logic                    capture_en_q;
    logic [1:0]              ev_sel_q;
    logic [7:0]              didr_q;
    logic [7:0]              conv_q;
    logic                    wait_q;
    logic [31:0]             rdata_q;
    logic [SYNC_STAGES-1:0]  res_sync_q;
    logic                    res_prev_q;
    logic [1:0]              din_meta_q;
    logic [1:0]              din_sync_q;
    logic                    irq_q;
    logic                    capture_q;
    logic [1:0]              port_in_q;
    logic [MV_W-1:0]         pos_mv;
    logic [MV_W-1:0]         neg_mv;
    logic [4:0]              ch_code;
    logic                    raw_cmp;
    logic                    result;
    logic                    event_hit;
    logic                    bus_req;
    logic                    bus_take;
    logic                    wr_low;
    logic                    flag_clr;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    // Negative input voltage for a given setting: the 1.1 V reference for code 1, the 2.56 V reference shifted right by div for code 3, the pin voltage otherwise.
    function automatic logic [MV_W-1:0] ref_mv(input logic [1:0] refs, input logic [1:0] div,
                                               input logic [MV_W-1:0] pin_mv);
        logic [MV_W-1:0] v;
        v = pin_mv;
        if (refs == REF_SEL_1V1)
        begin
            v = MV_1V1;
        end
        else if (refs == REF_SEL_2V56)
        begin
            v = MV_2V56 >> div;
        end
        return v;
    endfunction

    // Whether a pair of successive result samples is the selected event.
    function automatic logic ev_match(input logic [1:0] sel, input logic now, input logic prev);
        logic hit;
        hit = 1'b0;
        unique case (sel)
            EV_TOGGLE:  hit = now ^ prev;
            EV_FALLING: hit = prev & ~now;
            EV_RISING:  hit = now & ~prev;
            default:    hit = 1'b0;
        endcase
        return hit;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Multiplexer channel code; the low four bits index the channel table.
    assign ch_code = conv_q[CNV_CH_HI -: 5];

    // Analog input selection and the comparator decision itself.
    always_comb
    begin
        pos_mv = pins.pos_pin_mv;
        if (ctrl_b_q[CTB_MUX_EN] && !conv_q[CNV_ENABLE])
        begin
            pos_mv = '0;
            if (ch_code <= CH_MAX)
            begin
                pos_mv = channel_mv[ch_code[3:0]];
            end
        end
        neg_mv = pins.neg_pin_mv;
        if (int_ref_q)
        begin
            neg_mv = ref_mv(conv_q[CNV_REF_HI -: 2], ctrl_b_q[CTB_DIV_HI -: 2], pins.neg_pin_mv);
        end
        raw_cmp = !power_off_q && (pos_mv > neg_mv);
    end

    // Two-stage synchroniser of the raw decision; only the last stage is read.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            res_sync_q <= '0;
            res_prev_q <= 1'b0;
        end
        else
        begin
            res_sync_q <= {res_sync_q[SYNC_STAGES-2:0], raw_cmp};
            res_prev_q <= res_sync_q[SYNC_STAGES-1];
        end
    end

    assign result    = res_sync_q[SYNC_STAGES-1];
    assign event_hit = ev_match(ev_sel_q, result, res_prev_q);

    ////////////////////////////////////////////////////////////////////////
    // Bus handshake: one wait cycle, then the access completes.
    assign bus_req  = avs_req.read | avs_req.write;
    assign bus_take = bus_req & ~wait_q;
    assign wr_low   = bus_take & avs_req.write & avs_req.byteenable[0];

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wait_q <= 1'b1;
        end
        else
        begin
            wait_q <= ~(bus_req & wait_q);
        end
    end

    // Read data is captured while waitrequest drops and holds through the take.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rdata_q <= '0;
        end
        else if (avs_req.read && wait_q)
        begin
            rdata_q <= '0;
            unique case (avs_req.address)
                A_CTRL_B: rdata_q[7:0] <= ctrl_b_q;
                A_CSR:    rdata_q[7:0] <= {power_off_q, int_ref_q, result, flag_q,
                                           irq_en_q, capture_en_q, ev_sel_q};
                A_DIDR:   rdata_q[7:0] <= didr_q;
                A_CONV:   rdata_q[7:0] <= conv_q;
                A_ISTAT:  rdata_q[IRQ_EVENT] <= flag_q;
                A_IMASK:  rdata_q[IRQ_EVENT] <= irq_en_q;
                default:  rdata_q <= '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Plain configuration registers.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl_b_q <= RST_BYTE;
            didr_q   <= RST_BYTE;
            conv_q   <= RST_BYTE;
        end
        else if (wr_low)
        begin
            if (avs_req.address == A_CTRL_B)
            begin
                ctrl_b_q <= {1'b0, avs_req.writedata[CTB_MUX_EN:CTB_DIV_HI-1], 1'b0,
                             avs_req.writedata[CTB_TRIG_HI:0]};
            end
            if (avs_req.address == A_DIDR)
            begin
                didr_q <= avs_req.writedata[7:0];
            end
            if (avs_req.address == A_CONV)
            begin
                conv_q <= avs_req.writedata[7:0];
            end
        end
    end

    // Comparator control bits; power-off may be written at any time.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            power_off_q  <= 1'b0;
            int_ref_q    <= 1'b0;
            capture_en_q <= 1'b0;
            ev_sel_q     <= EV_TOGGLE;
        end
        else if (wr_low && avs_req.address == A_CSR)
        begin
            power_off_q  <= avs_req.writedata[CSR_POWER_OFF];
            int_ref_q    <= avs_req.writedata[CSR_INT_REF];
            capture_en_q <= avs_req.writedata[CSR_CAPTURE];
            ev_sel_q     <= avs_req.writedata[CSR_EVSEL_HI -: 2];
        end
    end

    // Interrupt enable, reachable through the control register and the mask.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            irq_en_q <= 1'b0;
        end
        else if (wr_low && avs_req.address == A_CSR)
        begin
            irq_en_q <= avs_req.writedata[CSR_IRQ_EN];
        end
        else if (wr_low && avs_req.address == A_IMASK)
        begin
            irq_en_q <= avs_req.writedata[IRQ_EVENT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky event flag; a new event in the clearing cycle keeps it set.
    always_comb
    begin
        flag_clr = irq_taken
                 | (wr_low && avs_req.address == A_CSR && avs_req.writedata[CSR_FLAG])
                 | (wr_low && avs_req.address == A_ISTAT && avs_req.writedata[IRQ_EVENT]);
        flag_d   = event_hit | (flag_q & ~flag_clr);
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            flag_q <= 1'b0;
        end
        else
        begin
            flag_q <= flag_d;
        end
    end

    // Interrupt request and timer capture route, both registered.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            irq_q     <= 1'b0;
            capture_q <= 1'b0;
        end
        else
        begin
            irq_q     <= flag_q & irq_en_q & global_irq_enable;
            capture_q <= capture_en_q & result;
        end
    end

    // Digital pin inputs: synchronised, then forced low while disabled.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            din_meta_q <= '0;
            din_sync_q <= '0;
            port_in_q  <= '0;
        end
        else
        begin
            din_meta_q <= pin_digital_in;
            din_sync_q <= din_meta_q;
            port_in_q  <= din_sync_q & ~{didr_q[DID_POS_OFF], didr_q[DID_NEG_OFF]};
        end
    end

    assign avs_rsp.readdata    = rdata_q;
    assign avs_rsp.waitrequest = wait_q;
    assign irq                 = irq_q;
    assign capture_trigger     = capture_q;
    assign comparator_power_off = power_off_q;
    assign pin_input_off       = {didr_q[DID_POS_OFF], didr_q[DID_NEG_OFF]};
    assign port_input          = port_in_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks kept next to the logic.
    sequence s_rise_seen;
        ev_sel_q == EV_RISING && result && !res_prev_q;
    endsequence

    sequence s_off_held;
        power_off_q [*3];
    endsequence

    sequence s_fall_seen;
        ev_sel_q == EV_FALLING && !result && res_prev_q;
    endsequence

    sequence s_toggle_seen;
        ev_sel_q == EV_TOGGLE && (result != res_prev_q);
    endsequence

    chk_sync_lag: assert property (result == $past(raw_cmp, 2))
        else $error("Result does not follow the raw decision by two clocks.");
    chk_rise_sets: assert property (s_rise_seen |=> flag_q)
        else $error("Rising edge did not set the flag.");
    chk_reserved_quiet: assert property (ev_sel_q == 2'h1 && !flag_q |=> !flag_q)
        else $error("Reserved event code set the flag.");
    chk_w1c_clear: assert property (flag_clr && !event_hit |=> !flag_q)
        else $error("Flag survived a clear.");
    chk_ack_clear: assert property (irq_taken && !event_hit ##1 !event_hit |=> !flag_q)
        else $error("Flag survived the vector being taken.");
    chk_irq_gate: assert property (irq |-> $past(flag_q && irq_en_q && global_irq_enable))
        else $error("Interrupt raised without flag and both enables.");
    chk_power_off: assert property (s_off_held |-> !result)
        else $error("Powered-off comparator shows a high result.");
    chk_neg_ref: assert property (int_ref_q && conv_q[CNV_REF_HI -: 2] == REF_SEL_1V1 |-> neg_mv == MV_1V1)
        else $error("Negative input is not the 1.1 V reference.");
    chk_pos_pin: assert property (!ctrl_b_q[CTB_MUX_EN] |-> pos_mv == pins.pos_pin_mv)
        else $error("Positive pin not selected with the mux off.");
    chk_capture_route: assert property (!capture_en_q ##1 !capture_en_q |-> !capture_trigger)
        else $error("Capture trigger driven with routing off.");
    chk_pin_gate: assert property (didr_q[DID_POS_OFF] |=> !port_input[1])
        else $error("Disabled positive pin reads high.");
    chk_bus_answer: assert property (bus_req && wait_q |=> !avs_rsp.waitrequest)
        else $error("Bus request not answered in one wait cycle.");
    // Remaining event modes, input routing, pin gating and the interrupt raise.
    chk_fall_sets: assert property (s_fall_seen |=> flag_q)
        else $error("Falling edge did not set the flag.");
    chk_toggle_sets: assert property (s_toggle_seen |=> flag_q)
        else $error("Output toggle did not set the flag.");
    chk_flag_hold: assert property (flag_q && !flag_clr |=> flag_q)
        else $error("Flag dropped without a clear.");
    chk_neg_pin: assert property (!int_ref_q |-> neg_mv == pins.neg_pin_mv)
        else $error("Negative pin not selected with the internal reference off.");
    chk_capture_on: assert property (capture_en_q |=> capture_trigger == $past(result))
        else $error("Capture trigger does not follow the result with routing on.");
    chk_neg_gate: assert property (didr_q[DID_NEG_OFF] |=> !port_input[0])
        else $error("Disabled negative pin reads high.");
    chk_irq_raise: assert property (flag_q && irq_en_q && global_irq_enable |=> irq)
        else $error("Interrupt not raised with flag and both enables set.");

endmodule

// file: bench/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import ccl_pkg::*;

    logic                      clk;
    logic                      nrst;
    ccl_avs_req_t              avs_req;
    ccl_avs_rsp_t              avs_rsp;
    ccl_pins_t                 pins;
    logic [N_CH-1:0][MV_W-1:0] channel_mv;
    logic [1:0]                pin_digital_in;
    logic                      global_irq_enable;
    logic                      irq_taken;
    logic                      irq;
    logic                      capture_trigger;
    logic                      comparator_power_off;
    logic [1:0]                pin_input_off;
    logic [1:0]                port_input;
    int                        fail_count;
    int                        checked;
    int                        cycles;
    logic [7:0]                rd;

    ccl_comparator_ctrl ccl_comparator_ctrl_i (
        .clk                  (clk),
        .nrst                 (nrst),
        .avs_req              (avs_req),
        .avs_rsp              (avs_rsp),
        .pins                 (pins),
        .channel_mv           (channel_mv),
        .pin_digital_in       (pin_digital_in),
        .global_irq_enable    (global_irq_enable),
        .irq_taken            (irq_taken),
        .irq                  (irq),
        .capture_trigger      (capture_trigger),
        .comparator_power_off (comparator_power_off),
        .pin_input_off        (pin_input_off),
        .port_input           (port_input)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Free-running clock; the cycle counter cuts a hung run short.
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            test_done();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Prints the counts and the verdict, then ends the run.
    task automatic test_done();
        $display("checks %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Compares a seen value with the expected one and counts both outcomes.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // One bus cycle: request held until waitrequest is sampled low, then released.
    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] wd, output logic [7:0] rdat);
        avs_req.read <= ~wr;
        avs_req.write <= wr;
        avs_req.address <= a;
        avs_req.writedata <= {24'h000000, wd};
        avs_req.byteenable <= 4'hF;
        @(posedge clk);
        while (avs_rsp.waitrequest !== 1'b0)
            @(posedge clk);
        rdat = avs_rsp.readdata[7:0];
        avs_req.read <= 1'b0;
        avs_req.write <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [7:0] wd);
        logic [7:0] dummy;
        bus(1'b1, a, wd, dummy);
    endtask

    task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [7:0] rdat);
        bus(1'b0, a, 8'h00, rdat);
    endtask

    // Voltage of multiplexer channel ch, distinct for every channel.
    function automatic logic [MV_W-1:0] chv(input int ch);
        return MV_W'(ch * 256 + 128);
    endfunction

    // Programs the three selection registers, lets the result settle and reads it.
    task automatic expect_result(input logic [7:0] ctb, input logic [7:0] csr, input logic [7:0] cnv,
                                 input logic exp);
        wr_reg(A_CTRL_B, ctb);
        wr_reg(A_CSR, csr);
        wr_reg(A_CONV, cnv);
        repeat (4) @(posedge clk);
        rd_reg(A_CSR, rd);
        check(rd[CSR_RESULT], exp);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Reset values, and an unmapped address that reads zero and ignores writes.
    task automatic t_reset();
        logic [ADDR_W-1:0] regs [6];
        regs = '{A_CTRL_B, A_CSR, A_DIDR, A_CONV, A_ISTAT, A_IMASK};
        foreach (regs[i])
        begin
            rd_reg(regs[i], rd);
            check(rd, RST_BYTE);
        end
        wr_reg(5'h18, 8'hFF);
        rd_reg(5'h18, rd);
        check(rd, 8'h00);
        check({irq, capture_trigger, comparator_power_off, pin_input_off}, 5'h00);
        $display("test reset done");
    endtask

    // Input selection on both sides of the comparator.
    task automatic t_compare();
        pins <= '{12'h1F4, 12'h190};
        expect_result(8'h00, 8'h00, 8'h00, 1'b1);
        pins <= '{12'h190, 12'h190};
        expect_result(8'h00, 8'h00, 8'h00, 1'b0);
        pins <= '{12'h44D, 12'h500};
        expect_result(8'h30, 8'h40, 8'h20, 1'b1);
        expect_result(8'h30, 8'h00, 8'h20, 1'b0);
        expect_result(8'h30, 8'h40, 8'h00, 1'b0);
        pins.pos_pin_mv <= MV_1V1;
        expect_result(8'h00, 8'h40, 8'h20, 1'b0);
        for (int d = 0; d < 4; d++)
        begin
            pins <= '{(MV_2V56 >> d) + 12'h001, 12'hFFF};
            expect_result({2'b00, 2'(d), 4'h0}, 8'h40, 8'h60, 1'b1);
            pins.pos_pin_mv <= MV_2V56 >> d;
            expect_result({2'b00, 2'(d), 4'h0}, 8'h40, 8'h60, 1'b0);
        end
        for (int ch = 0; ch < N_CH; ch++)
        begin
            pins <= '{12'h000, chv(ch) - 12'h001};
            expect_result(8'h40, 8'h00, {3'b000, 5'(ch)}, 1'b1);
            pins.neg_pin_mv <= chv(ch);
            expect_result(8'h40, 8'h00, {3'b000, 5'(ch)}, 1'b0);
        end
        pins <= '{12'h000, 12'h001};
        expect_result(8'h40, 8'h00, 8'h80, 1'b0);
        expect_result(8'h00, 8'h00, 8'h00, 1'b0);
        $display("test compare done");
    endtask

    // Every event select code against a rising and a falling result.
    task automatic t_events();
        logic [1:0] m;
        for (int i = 0; i < 4; i++)
        begin
            m = 2'(i);
            pins <= '{12'h100, 12'h200};
            wr_reg(A_CSR, {6'h00, m});
            repeat (4) @(posedge clk);
            wr_reg(A_CSR, {6'h04, m});
            pins.pos_pin_mv <= 12'h300;
            repeat (6) @(posedge clk);
            rd_reg(A_ISTAT, rd);
            check(rd[IRQ_EVENT], m == EV_TOGGLE || m == EV_RISING);
            wr_reg(A_CSR, {6'h04, m});
            pins.pos_pin_mv <= 12'h100;
            repeat (6) @(posedge clk);
            rd_reg(A_CSR, rd);
            check(rd[CSR_FLAG], m == EV_TOGGLE || m == EV_FALLING);
        end
        $display("test events done");
    endtask

    // Interrupt gating, clearing the flag by an ISTAT write and by irq_taken, and the capture route.
    task automatic t_irq();
        wr_reg(A_CSR, 8'h13);
        wr_reg(A_CSR, 8'h0B);
        pins.pos_pin_mv <= 12'h300;
        repeat (6) @(posedge clk);
        check(irq, 1'b0);
        global_irq_enable <= 1'b1;
        repeat (3) @(posedge clk);
        check(irq, 1'b1);
        wr_reg(A_IMASK, 8'h00);
        repeat (3) @(posedge clk);
        check(irq, 1'b0);
        wr_reg(A_IMASK, 8'h01);
        repeat (3) @(posedge clk);
        check(irq, 1'b1);
        wr_reg(A_CSR, 8'h0B);
        rd_reg(A_CSR, rd);
        check(rd[CSR_FLAG], 1'b1);
        wr_reg(A_ISTAT, 8'h01);
        repeat (3) @(posedge clk);
        check(irq, 1'b0);
        pins.pos_pin_mv <= 12'h100;
        repeat (6) @(posedge clk);
        rd_reg(A_CSR, rd);
        check(rd[CSR_FLAG], 1'b0);
        pins.pos_pin_mv <= 12'h300;
        repeat (6) @(posedge clk);
        check(irq, 1'b1);
        irq_taken <= 1'b1;
        @(posedge clk);
        irq_taken <= 1'b0;
        repeat (3) @(posedge clk);
        check(irq, 1'b0);
        global_irq_enable <= 1'b0;
        // The global enable goes off before the interrupt enable and route bits change.
        wr_reg(A_CSR, 8'h03);
        // The timer's own capture enable sits outside; only the route is driven here.
        wr_reg(A_CSR, 8'h07);
        repeat (4) @(posedge clk);
        check(capture_trigger, 1'b1);
        pins.pos_pin_mv <= 12'h100;
        repeat (2) @(posedge clk);
        check(capture_trigger, 1'b1);
        repeat (4) @(posedge clk);
        check(capture_trigger, 1'b0);
        wr_reg(A_CSR, 8'h03);
        pins.pos_pin_mv <= 12'h300;
        repeat (5) @(posedge clk);
        check(capture_trigger, 1'b0);
        $display("test irq done");
    endtask

    // Power-off bit and the digital input buffers of the two pins.
    task automatic t_power_pins();
        wr_reg(A_CSR, 8'h83);
        repeat (4) @(posedge clk);
        check(comparator_power_off, 1'b1);
        rd_reg(A_CSR, rd);
        check({rd[CSR_POWER_OFF], rd[CSR_RESULT]}, 2'b10);
        wr_reg(A_CSR, 8'h03);
        check(comparator_power_off, 1'b0);
        pin_digital_in <= 2'b11;
        repeat (4) @(posedge clk);
        check(port_input, 2'b11);
        wr_reg(A_DIDR, 8'hC0);
        repeat (4) @(posedge clk);
        check({pin_input_off, port_input}, 4'hC);
        wr_reg(A_DIDR, 8'h40);
        repeat (4) @(posedge clk);
        check({pin_input_off, port_input}, 4'h6);
        rd_reg(A_DIDR, rd);
        check(rd, 8'h40);
        $display("test power and pins done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence: inputs defined at time zero, reset held, then the tests.
    initial
    begin
        fail_count = 0;
        checked = 0;
        cycles = 0;
        nrst = 1'b0;
        avs_req = '0;
        pins = '0;
        pin_digital_in = 2'b00;
        global_irq_enable = 1'b0;
        irq_taken = 1'b0;
        for (int ch = 0; ch < N_CH; ch++)
            channel_mv[ch] = chv(ch);
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        t_reset();
        t_compare();
        t_events();
        t_irq();
        t_power_pins();
        test_done();
    end
endmodule
